// ==== rtl/branch_pkg.sv ====
package branch_pkg;
  // instruction word layout (16-bit word, 7-bit offset, 3-bit flag select)
  localparam int INSN_W = 16;
  localparam int OFS_LSB = 3;
  localparam int OFS_W = 7;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int POL_BIT = 10; // 0: branch when flag set, 1: when clear
  localparam logic [5:0] OPC_VAL = 6'h3C; // bits 15:10 = 1111 0x
  localparam int OPC_LSB = 11;
  localparam logic [4:0] OPC_TOP = 5'h1E;
  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  // cycle counts
  localparam int CYC_NOT_TAKEN = 1;
  localparam int CYC_TAKEN = 2;
  typedef enum logic [3:0] {
    OP_NONE, OP_NOT_EQUAL, OP_CARRY_SET, OP_CARRY_CLEAR, OP_SAME_OR_HIGHER,
    OP_LOWER, OP_MINUS, OP_PLUS, OP_GE_SIGNED, OP_LT_SIGNED, OP_HALF_SET, OP_OTHER
  } branch_op_t;
endpackage

// ==== rtl/cond_branch_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module cond_branch_unit #(
  parameter int PC_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic insn_valid,
  input wire logic [branch_pkg::INSN_W-1:0] insn_word,
  input wire logic [7:0] sreg_in,
  output logic insn_ready,
  output logic is_branch,
  output logic branch_taken,
  output logic [PC_W-1:0] pc,
  output logic flush,
  output logic [7:0] sreg_out
);

  // ***********************************************
  // elaboration checks
  // ***********************************************

  // cycles spent refilling after a taken branch, beyond the first one
  localparam int REFILL_CYC = branch_pkg::CYC_TAKEN - branch_pkg::CYC_NOT_TAKEN;

  initial begin
    if (PC_W < branch_pkg::OFS_W || PC_W > 32) begin
      $error("PC_W out of range");
    end
    // the fields of the word must not overlap, or decode reads garbage
    if (branch_pkg::OFS_LSB + branch_pkg::OFS_W > branch_pkg::POL_BIT) begin
      $error("offset field overlaps polarity bit");
    end
    if (branch_pkg::SEL_LSB + branch_pkg::SEL_W > branch_pkg::OFS_LSB) begin
      $error("select field overlaps offset field");
    end
    if (branch_pkg::POL_BIT >= branch_pkg::OPC_LSB) begin
      $error("polarity bit overlaps opcode field");
    end
    // the refill counter below is four bits wide
    if (REFILL_CYC < 1 || REFILL_CYC > 15) begin
      $error("taken branch cycle count out of range");
    end
  end

  // ***********************************************
  // decode
  // ***********************************************

  // the opcode field picks the branch group; everything else is a plain
  // word that only steps the program counter. limitation: the selects
  // that name no condition are treated like plain words, never trapped
  // flag select plus polarity maps onto the named branches
  function automatic branch_pkg::branch_op_t decode_op(
    input logic [branch_pkg::INSN_W-1:0] w
  );
    logic pol;
    logic [2:0] sel;
    pol = w[branch_pkg::POL_BIT];
    sel = w[branch_pkg::SEL_LSB +: branch_pkg::SEL_W];
    decode_op = branch_pkg::OP_NONE;
    if (w[branch_pkg::INSN_W-1:branch_pkg::OPC_LSB] == branch_pkg::OPC_TOP) begin
      case (sel)
        3'h0: decode_op = pol ? branch_pkg::OP_CARRY_CLEAR : branch_pkg::OP_CARRY_SET;
        3'h1: decode_op = pol ? branch_pkg::OP_NOT_EQUAL : branch_pkg::OP_OTHER;
        3'h2: decode_op = pol ? branch_pkg::OP_PLUS : branch_pkg::OP_MINUS;
        3'h4: decode_op = pol ? branch_pkg::OP_GE_SIGNED : branch_pkg::OP_LT_SIGNED;
        3'h5: decode_op = pol ? branch_pkg::OP_OTHER : branch_pkg::OP_HALF_SET;
        default: decode_op = branch_pkg::OP_OTHER;
      endcase
    end
  endfunction

  // condition test; same_or_higher/lower share the carry encodings
  function automatic logic cond_true(input branch_pkg::branch_op_t op,
                                     input logic [7:0] s);
    logic nv;
    nv = s[branch_pkg::FLAG_N] ^ s[branch_pkg::FLAG_V];
    case (op)
      branch_pkg::OP_NOT_EQUAL: cond_true = ~s[branch_pkg::FLAG_Z];
      branch_pkg::OP_CARRY_SET: cond_true = s[branch_pkg::FLAG_C];
      branch_pkg::OP_LOWER: cond_true = s[branch_pkg::FLAG_C];
      branch_pkg::OP_CARRY_CLEAR: cond_true = ~s[branch_pkg::FLAG_C];
      branch_pkg::OP_SAME_OR_HIGHER: cond_true = ~s[branch_pkg::FLAG_C];
      branch_pkg::OP_MINUS: cond_true = s[branch_pkg::FLAG_N];
      branch_pkg::OP_PLUS: cond_true = ~s[branch_pkg::FLAG_N];
      branch_pkg::OP_GE_SIGNED: cond_true = ~nv;
      branch_pkg::OP_LT_SIGNED: cond_true = nv;
      branch_pkg::OP_HALF_SET: cond_true = s[branch_pkg::FLAG_H];
      default: cond_true = 1'b0;
    endcase
  endfunction

  // only the named conditions count as branches; dead encodings just step
  function automatic logic is_named(input branch_pkg::branch_op_t op);
    case (op)
      branch_pkg::OP_NONE: is_named = 1'b0;
      branch_pkg::OP_OTHER: is_named = 1'b0;
      default: is_named = 1'b1;
    endcase
  endfunction

  // run accepts one word a cycle; refill blocks fetch while the pipeline
  // reloads from the branch target, which costs the extra taken cycle
  // and keeps a stale word from being executed
  typedef enum logic [0:0] {ST_RUN, ST_REFILL} state_t;

  state_t state_q, state_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic taken_q, taken_d;
  logic brn_q, brn_d;
  // remaining refill cycles
  logic [3:0] refill_q, refill_d;
  branch_pkg::branch_op_t op;
  logic hit;
  logic [PC_W-1:0] ofs_ext;

  // ***********************************************
  // sequencing
  // ***********************************************

  assign op = decode_op(insn_word);
  assign hit = cond_true(op, sreg_in);
  // sign extension keeps backward branches correct at any pc width
  assign ofs_ext = PC_W'($signed(insn_word[branch_pkg::OFS_LSB +: branch_pkg::OFS_W]));
  // refill cycle stalls fetch; this is the second cycle of a taken branch
  assign insn_ready = (state_q == ST_RUN);
  assign flush = (state_q == ST_REFILL);
  assign pc = pc_q;
  assign branch_taken = taken_q;
  assign is_branch = brn_q;
  // flags pass straight through untouched
  assign sreg_out = sreg_in;

  // next pc and state
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    taken_d = 1'b0;
    brn_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (insn_valid) begin
          brn_d = is_named(op);
          if (hit) begin
            pc_d = pc_q + ofs_ext + PC_W'(1);
            taken_d = 1'b1;
            state_d = ST_REFILL;
          end else begin
            pc_d = pc_q + PC_W'(1);
          end
        end
      end
      ST_REFILL: begin
        // leave once the last refill cycle is under way
        if (refill_q <= 4'h1) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ***********************************************
  // refill counter
  // ***********************************************

  // loaded on a taken branch, counts down through the refill state
  always_comb begin
    refill_d = refill_q;
    if (state_q == ST_RUN && taken_d) begin
      refill_d = 4'(REFILL_CYC);
    end else if (refill_q != 4'h0) begin
      refill_d = refill_q - 4'h1;
    end
  end

  // counter register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      refill_q <= 4'h0;
    end else begin
      refill_q <= refill_d;
    end
  end

  // ***********************************************
  // registers
  // ***********************************************

  // state, program counter and the two result pulses
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
      pc_q <= PC_W'(branch_pkg::PC_RST);
      taken_q <= 1'b0;
      brn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      taken_q <= taken_d;
      brn_q <= brn_d;
    end
  end

endmodule
`default_nettype wire

// ==== verif/branch_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module branch_checker #(parameter int PC_W = 16) (
  input wire logic sys_clk, nrst, insn_valid, insn_ready, is_branch, branch_taken, flush,
  input wire logic [15:0] insn_word,
  input wire logic [7:0] sreg_in, sreg_out,
  input wire logic [PC_W-1:0] pc);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // reference decode; the dead set-zero and clear-half words must not branch
  wire [2:0] s = insn_word[2:0];
  wire p = insn_word[10];
  wire ok = insn_word[15:11] == 5'h1E && (s inside {0, 2, 4} || s == 1 && p || s == 5 && !p);
  wire tk = ok && ((s == 4 ? sreg_in[2] ^ sreg_in[3] : sreg_in[s]) ^ p);
  wire acc = insn_valid && insn_ready;
  wire [PC_W-1:0] k = PC_W'($signed(insn_word[9:3]));
  chk_taken_pc: assert property (acc && tk |=> pc == PC_W'($past(pc) + $past(k) + 1))
    else $error("target");
  chk_next_pc: assert property (acc && !tk |=> pc == PC_W'($past(pc) + 1)) else $error("pc");
  chk_taken_flag: assert property (acc |=> branch_taken == $past(tk))
    else $error("taken");
  chk_is_branch: assert property (acc |=> is_branch == $past(ok)) else $error("decode");
  chk_refill_gap: assert property (acc && tk |=> !insn_ready ##1 insn_ready) else $error("gap");
  chk_idle_hold: assert property (!acc |=> !is_branch && $stable(pc)) else $error("idle");
  chk_flush_ready: assert property (flush == !insn_ready) else $error("flush");
  chk_flags_kept: assert property (sreg_out == sreg_in) else $error("flags");
  cover property (acc && tk);
  cover property (acc && ok && !tk);
  cover property (acc && !ok);
endmodule
bind cond_branch_unit branch_checker #(.PC_W(PC_W)) branch_checker_inst (.*);
`default_nettype wire

// ==== verif/fetch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// fetch side: a word stands until a rising edge samples ready high
module fetch_model (input wire logic sys_clk, insn_ready,
  output logic insn_valid = 0, output logic [15:0] insn_word = 0, output logic [7:0] sreg_in = 0);
  task automatic issue(input logic [15:0] w, input logic [7:0] f, input logic hold);
    @(negedge sys_clk);
    {insn_valid, insn_word, sreg_in} = {1'b1, w, f};
    while (insn_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    // released lines show the inverse so a stale word never looks fresh
    if (!hold) @(negedge sys_clk) {insn_valid, insn_word} = {1'b0, ~w};
  endtask
endmodule
`default_nettype wire

// ==== verif/test_conditional_relative_branch.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_conditional_relative_branch;
  logic sys_clk = 0, nrst = 0, insn_valid, insn_ready, is_branch, branch_taken, flush, t;
  logic [15:0] insn_word, pc, ep = 0, w;
  logic [7:0] sreg_in, sreg_out, f;
  logic [4:0] e;
  logic [16:0] q[$];
  int miscompares = 0, tests_run = 0, cyc = 0;
  // {branches, polarity, select}: every condition plus the two dead encodings
  logic [4:0] tbl[10] = '{5'h10, 5'h18, 5'h19, 5'h12, 5'h1A, 5'h14, 5'h1C, 5'h15, 5'h01, 5'h0D};
  always #2.5 sys_clk = ~sys_clk;
  cond_branch_unit #(.PC_W(16)) cond_branch_unit_inst (.*);
  fetch_model fetch_model_inst (.*);
  task automatic check(input logic [16:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // each branch pulse takes the oldest note; the ceiling cuts a hang short
  always @(negedge sys_clk) begin
    if (is_branch === 1'b1)
      check({branch_taken, pc}, q.size() ? q.pop_front() : 'x);
    if (insn_valid === 1'b1)
      check({9'h000, sreg_out}, {9'h000, sreg_in});
    if (++cyc == 2000) begin
      miscompares++;
      close_out();
    end
  end
  // odd pairs run back to back, so a word also waits out each refill gap that follows a held word
  initial begin
    void'($urandom(93));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) nrst = 1;
    for (int i = 0; i < 80; i++) begin
      e = tbl[i % 10];
      f = 8'($urandom());
      f[4] = f[2] ^ f[3];
      w = {5'h1E, e[3], i == 5 ? 7'h40 : 7'($urandom()), e[2:0]};
      t = e[4] && ((e[2:0] == 4 ? f[4] : f[e[2:0]]) ^ e[3]);
      ep = ep + 16'h0001 + (t ? {{9{w[9]}}, w[9:3]} : 16'h0000);
      if (e[4]) q.push_back({t, ep});
      fetch_model_inst.issue(w, f, i[1] && i < 79);
    end
    repeat (3) @(negedge sys_clk);
    check(q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
